// ===== hdl/etc_core.sv
// Eight-bit timer counter core with two compare units
`timescale 1ns/1ps
`default_nettype none
module etc_core #(
	parameter int WIDTH = etc_pkg::CNT_W
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Counter and compare writes
	input wire etc_pkg::etc_wr_t counter_value_wr,
	input wire etc_pkg::etc_wr_t compare_value_a_wr,
	input wire etc_pkg::etc_wr_t compare_value_b_wr,
	// Control fields
	input wire logic [2:0] clock_source_select,
	input wire logic [1:0] waveform_mode_lo,
	input wire logic waveform_mode_bit2,
	input wire logic [2:0] timer_mask_register,
	// Flag clearing: write one, or interrupt serviced
	input wire logic [2:0] flag_clear,
	// External count input
	input wire logic external_count_input,
	// Readback
	output logic [7:0] counter_value,
	output logic [7:0] compare_value_a,
	output logic [7:0] compare_value_b,
	output logic [2:0] timer_flag_register,
	output logic [2:0] timer_irq,
	// To waveform generator
	output logic match_a,
	output logic match_b,
	output logic at_bottom,
	output logic at_max,
	output logic at_top,
	output logic count_down,
	output logic timer_tick
);
	// ****************************************
	// Tick generation
	// ****************************************
	logic [etc_pkg::PRE_W-1:0] pre_ff;
	logic ext_ff;
	logic tick;
	logic [2:0] mode;
	logic pwm;
	logic [7:0] top_val;
	logic [7:0] cnt_ff, ocra_ff, ocrb_ff, bufa_ff, bufb_ff;
	logic dir_ff, block_ff;
	logic [2:0] flg_ff;
	logic [7:0] nxt_cnt;
	logic nxt_dir, ovf_ev;
	logic ext_ok_ff;
	logic ext_rise, ext_fall;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_ff <= '0;
			ext_ff <= 1'b0;
			ext_ok_ff <= 1'b0;
		end else if (clk_en) begin
			pre_ff <= pre_ff + 1'b1; // R4
			ext_ff <= external_count_input;
			ext_ok_ff <= 1'b1;
		end
	end

	// No pin edge until one real pin sample is held, so no false edge after reset
	assign ext_rise = ext_ok_ff & ~ext_ff & external_count_input;
	assign ext_fall = ext_ok_ff & ext_ff & ~external_count_input;

	always_comb begin
		case (clock_source_select) // R5 R6
			etc_pkg::CS_STOP: tick = 1'b0; // R7
			etc_pkg::CS_DIV1: tick = 1'b1; // R4
			etc_pkg::CS_DIV8: tick = &pre_ff[2:0];
			etc_pkg::CS_DIV64: tick = &pre_ff[5:0];
			etc_pkg::CS_DIV256: tick = &pre_ff[7:0];
			etc_pkg::CS_DIV1024: tick = &pre_ff[9:0];
			etc_pkg::CS_EXT_FALL: tick = ext_fall; // R4
			etc_pkg::CS_EXT_RISE: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end

	// ****************************************
	// Mode decode
	// ****************************************
	assign mode = {waveform_mode_bit2, waveform_mode_lo}; // R13
	assign pwm = (mode != etc_pkg::WM_NORMAL) && (mode != etc_pkg::WM_CTC); // R18
	assign top_val = (mode == etc_pkg::WM_CTC || mode == etc_pkg::WM_PC_OCA ||
		mode == etc_pkg::WM_FAST_OCA) ? ocra_ff : etc_pkg::CNT_MAX; // R12
	wire phase_corr = (mode == etc_pkg::WM_PC_FF) || (mode == etc_pkg::WM_PC_OCA);
	wire cur_top = (cnt_ff == top_val);

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_dir = dir_ff;
		ovf_ev = 1'b0;
		if (phase_corr) begin
			if (cur_top)
				nxt_dir = 1'b1;
			else if (cnt_ff == etc_pkg::CNT_BOTTOM)
				nxt_dir = 1'b0;
			nxt_cnt = nxt_dir ? cnt_ff - 8'h01 : cnt_ff + 8'h01; // R8
			ovf_ev = (cnt_ff == etc_pkg::CNT_BOTTOM) && dir_ff; // R16
		end else if (mode == etc_pkg::WM_CTC) begin
			nxt_dir = 1'b0;
			nxt_cnt = cur_top ? etc_pkg::CNT_BOTTOM : cnt_ff + 8'h01; // R8
			ovf_ev = (cnt_ff == etc_pkg::CNT_MAX); // R16
		end else if (mode == etc_pkg::WM_NORMAL) begin
			nxt_dir = 1'b0;
			nxt_cnt = cnt_ff + 8'h01; // R20
			ovf_ev = (cnt_ff == etc_pkg::CNT_MAX); // R20
		end else begin
			nxt_dir = 1'b0;
			nxt_cnt = cur_top ? etc_pkg::CNT_BOTTOM : cnt_ff + 8'h01; // R8
			ovf_ev = cur_top; // R16
		end
	end

	// ****************************************
	// Counter
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= etc_pkg::RST_VAL; // R21
			dir_ff <= 1'b0;
		end else if (clk_en) begin
			if (counter_value_wr.we)
				cnt_ff <= counter_value_wr.data; // R9 R10
			else if (tick) begin
				cnt_ff <= nxt_cnt; // R8
				dir_ff <= nxt_dir;
			end
		end
	end

	// Block matches for one tick after a counter write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			block_ff <= 1'b0;
		else if (clk_en) begin
			if (counter_value_wr.we)
				block_ff <= 1'b1; // R19
			else if (tick)
				block_ff <= 1'b0;
		end
	end

	// ****************************************
	// Compare registers
	// ****************************************
	wire upd_pt = phase_corr ? cur_top : (cnt_ff == etc_pkg::CNT_BOTTOM);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bufa_ff <= etc_pkg::RST_VAL; // R21
			bufb_ff <= etc_pkg::RST_VAL;
			ocra_ff <= etc_pkg::RST_VAL;
			ocrb_ff <= etc_pkg::RST_VAL;
		end else if (clk_en) begin
			if (compare_value_a_wr.we)
				bufa_ff <= compare_value_a_wr.data; // R1
			if (compare_value_b_wr.we)
				bufb_ff <= compare_value_b_wr.data;
			if (!pwm) begin
				if (compare_value_a_wr.we)
					ocra_ff <= compare_value_a_wr.data; // R18
				if (compare_value_b_wr.we)
					ocrb_ff <= compare_value_b_wr.data;
			end else if (tick && upd_pt) begin
				ocra_ff <= bufa_ff; // R18
				ocrb_ff <= bufb_ff;
			end
		end
	end

	// ****************************************
	// Flags
	// ****************************************
	wire raw_a = (cnt_ff == ocra_ff) && !block_ff; // R14 R19
	wire raw_b = (cnt_ff == ocrb_ff) && !block_ff;
	logic [2:0] set_v;
	assign set_v = tick ? {raw_b, raw_a, ovf_ev & ~counter_value_wr.we} : 3'b000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			flg_ff <= 3'b000; // R21
		else if (clk_en)
			flg_ff <= (flg_ff & ~flag_clear) | set_v; // R3 R15 R17
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			counter_value <= etc_pkg::RST_VAL;
			compare_value_a <= etc_pkg::RST_VAL;
			compare_value_b <= etc_pkg::RST_VAL;
			timer_flag_register <= 3'b000;
			timer_irq <= 3'b000;
			match_a <= 1'b0;
			match_b <= 1'b0;
			at_bottom <= 1'b0;
			at_max <= 1'b0;
			at_top <= 1'b0;
			count_down <= 1'b0;
			timer_tick <= 1'b0;
		end else if (clk_en) begin
			counter_value <= cnt_ff;
			compare_value_a <= pwm ? bufa_ff : ocra_ff;
			compare_value_b <= pwm ? bufb_ff : ocrb_ff;
			timer_flag_register <= flg_ff; // R2
			timer_irq <= flg_ff & timer_mask_register; // R2
			match_a <= raw_a; // R14
			match_b <= raw_b;
			at_bottom <= (cnt_ff == etc_pkg::CNT_BOTTOM); // R11
			at_max <= (cnt_ff == etc_pkg::CNT_MAX); // R11
			at_top <= cur_top; // R12
			count_down <= dir_ff;
			timer_tick <= tick; // R5
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	stop_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R7
		clk_en && clock_source_select == etc_pkg::CS_STOP && !counter_value_wr.we
		|=> $stable(cnt_ff)) else $error("counter moved while stopped");
	wr_wins_a: assert property (@(posedge clk) disable iff (!nrst) // R10
		clk_en && counter_value_wr.we |=> cnt_ff == $past(counter_value_wr.data))
		else $error("counter write lost");
	norm_wrap_a: assert property (@(posedge clk) disable iff (!nrst) // R20
		clk_en && tick && !counter_value_wr.we && mode == etc_pkg::WM_NORMAL
		&& cnt_ff == etc_pkg::CNT_MAX |=> cnt_ff == 8'h00 && flg_ff[0])
		else $error("normal wrap wrong");
	match_set_a: assert property (@(posedge clk) disable iff (!nrst) // R15
		clk_en && tick && raw_a |=> flg_ff[1]) else $error("flag a not set");
	wr_block_a: assert property (@(posedge clk) disable iff (!nrst) // R19
		clk_en && counter_value_wr.we |=> block_ff && !raw_a && !raw_b)
		else $error("match not blocked");
	flag_clr_a: assert property (@(posedge clk) disable iff (!nrst) // R17
		clk_en && flag_clear[2] && !set_v[2] |=> !flg_ff[2])
		else $error("flag b not cleared");
	irq_mask_a: assert property (@(posedge clk) disable iff (!nrst) // R2
		clk_en |=> timer_irq == ($past(flg_ff) & $past(timer_mask_register)))
		else $error("irq gating wrong");
	direct_cmp_a: assert property (@(posedge clk) disable iff (!nrst) // R18
		clk_en && !pwm && compare_value_a_wr.we
		|=> ocra_ff == $past(compare_value_a_wr.data)) else $error("direct write lost");
	ctc_clear_a: assert property (@(posedge clk) disable iff (!nrst) // R8
		clk_en && tick && !counter_value_wr.we && mode == etc_pkg::WM_CTC && cur_top
		|=> cnt_ff == 8'h00) else $error("ctc clear wrong");

	// ****************************************
	// Checks: status outputs, flags, buffers, phase-correct turn
	// ****************************************
	bottom_flag_a: assert property (@(posedge clk) disable iff (!nrst) // R11
		clk_en |=> at_bottom == ($past(cnt_ff) == etc_pkg::CNT_BOTTOM))
		else $error("bottom status wrong");
	max_flag_a: assert property (@(posedge clk) disable iff (!nrst) // R11
		clk_en |=> at_max == ($past(cnt_ff) == etc_pkg::CNT_MAX))
		else $error("max status wrong");
	top_out_a: assert property (@(posedge clk) disable iff (!nrst) // R12
		clk_en |=> at_top == ($past(cnt_ff) == $past(top_val)))
		else $error("top status wrong");
	tick_out_a: assert property (@(posedge clk) disable iff (!nrst) // R5
		clk_en |=> timer_tick == $past(tick))
		else $error("tick status wrong");
	match_out_a: assert property (@(posedge clk) disable iff (!nrst) // R14
		clk_en |=> match_b == $past(raw_b))
		else $error("match b status wrong");
	flag_keep_a: assert property (@(posedge clk) disable iff (!nrst) // R17
		clk_en && flg_ff[etc_pkg::FLG_CMPA] && !flag_clear[etc_pkg::FLG_CMPA]
		|=> flg_ff[etc_pkg::FLG_CMPA]) else $error("flag a lost");
	flag_keep_b_a: assert property (@(posedge clk) disable iff (!nrst) // R17
		clk_en && flg_ff[etc_pkg::FLG_CMPB] && !flag_clear[etc_pkg::FLG_CMPB]
		|=> flg_ff[etc_pkg::FLG_CMPB]) else $error("flag b lost");
	ovf_keep_a: assert property (@(posedge clk) disable iff (!nrst) // R16
		clk_en && flg_ff[etc_pkg::FLG_OVF] && !flag_clear[etc_pkg::FLG_OVF]
		|=> flg_ff[etc_pkg::FLG_OVF]) else $error("overflow flag lost");
	wr_ovf_a: assert property (@(posedge clk) disable iff (!nrst) // R10
		clk_en && counter_value_wr.we && !flg_ff[etc_pkg::FLG_OVF]
		|=> !flg_ff[etc_pkg::FLG_OVF]) else $error("overflow set by written count");
	pwm_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R18
		clk_en && pwm && !(tick && upd_pt)
		|=> ocra_ff == $past(ocra_ff) && ocrb_ff == $past(ocrb_ff))
		else $error("buffered compare moved early");
	direct_cmp_b_a: assert property (@(posedge clk) disable iff (!nrst) // R18
		clk_en && !pwm && compare_value_b_wr.we
		|=> ocrb_ff == $past(compare_value_b_wr.data)) else $error("direct write b lost");
	pc_turn_a: assert property (@(posedge clk) disable iff (!nrst) // R8
		clk_en && tick && !counter_value_wr.we && phase_corr && cur_top
		|=> dir_ff && cnt_ff == $past(cnt_ff) - 8'h01)
		else $error("phase correct turn wrong");
	ovf_pc_a: assert property (@(posedge clk) disable iff (!nrst) // R16
		clk_en && tick && !counter_value_wr.we && phase_corr && dir_ff
		&& cnt_ff == etc_pkg::CNT_BOTTOM |=> flg_ff[etc_pkg::FLG_OVF])
		else $error("bottom overflow lost");
	cov_ovf: cover property (@(posedge clk) disable iff (!nrst) set_v[0]);
	cov_cmpa: cover property (@(posedge clk) disable iff (!nrst) set_v[1]);
	cov_block: cover property (@(posedge clk) disable iff (!nrst)
		block_ff && tick && cnt_ff == ocra_ff);
	cov_down: cover property (@(posedge clk) disable iff (!nrst) dir_ff && tick);
	cov_ext: cover property (@(posedge clk) disable iff (!nrst)
		tick && clock_source_select == etc_pkg::CS_EXT_FALL);
endmodule
`default_nettype wire

// ===== common/etc_pkg.sv
// Package for the eight-bit timer counter core: constants and carrier types
// Notes on behaviour
// R1: Counter and both compare values are 8-bit, CPU readable and writable.
// R2: Each interrupt request shows in flag register and is gated by its mask bit.
// R3: Three interrupt sources: overflow, compare A, compare B.
// R4: Tick comes from prescaled internal clock or external count input.
// R5: Clock select picks source and edge; its output is the timer tick.
// R6: Three-bit clock source select in control register B picks tick source.
// R7: Select zero stops the counter: no count, no clear.
// R8: Each tick clears, increments or decrements the counter per mode.
// R9: CPU may read and write counter at any time.
// R10: CPU counter write wins over same-cycle clear or count.
// R11: Bottom reported at 0x00, max reported at 0xFF.
// R12: Top is 0xFF or compare value A depending on mode.
// R13: Mode chosen by two waveform bits in A plus third bit in B.
// R14: Both compares checked continuously; matches go to waveform generator.
// R15: Compare match on A or B sets its compare flag.
// R16: Overflow flag set per mode and usable as interrupt source.
// R17: Match flag sets on tick after match; cleared by service or writing one.
// R18: PWM modes double buffer compares, updating at top or bottom; else direct.
// R19: Counter write blocks compare matches in the next tick, even stopped.
// R20: Normal mode counts up, wraps 0xFF to 0x00, overflow set when zero.
// R21: Reset clears counter, compares, controls, flags and masks; controls and masks are core inputs, which the core does not reset.
package etc_pkg;
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] RST_VAL = 8'h00;
	// Flag and mask bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	// Clock source select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// Waveform mode codes
	localparam logic [2:0] WM_NORMAL = 3'h0;
	localparam logic [2:0] WM_PC_FF = 3'h1;
	localparam logic [2:0] WM_CTC = 3'h2;
	localparam logic [2:0] WM_FAST_FF = 3'h3;
	localparam logic [2:0] WM_PC_OCA = 3'h5;
	localparam logic [2:0] WM_FAST_OCA = 3'h7;
	localparam int PRE_W = 10;
	typedef struct packed {
		logic we;
		logic [7:0] data;
	} etc_wr_t;
	typedef struct packed {
		logic cmp_b;
		logic cmp_a;
		logic ovf;
	} etc_flags_t;
endpackage

// ===== test/tb_eight_bit_timer_counter_core.sv
// Self-checking bench for the timer counter core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_eight_bit_timer_counter_core;
	logic clk, nrst, clk_en, ext;
	etc_pkg::etc_wr_t cw, oaw, obw;
	logic [2:0] cs, msk, fclr, wm;
	logic [7:0] counter_value, compare_value_a, compare_value_b, mx;
	logic [2:0] timer_flag_register, timer_irq;
	logic dn;
	logic ma, mb, bot, amax, atop, cdn, ttk;
	int n_errors = 0;
	int check_count = 0;
	etc_core uut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .counter_value_wr(cw),
		.compare_value_a_wr(oaw), .compare_value_b_wr(obw), .clock_source_select(cs),
		.waveform_mode_lo(wm[1:0]), .waveform_mode_bit2(wm[2]), .timer_mask_register(msk),
		.flag_clear(fclr), .external_count_input(ext), .counter_value(counter_value),
		.compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
		.timer_flag_register(timer_flag_register), .timer_irq(timer_irq), .match_a(ma),
		.match_b(mb), .at_bottom(bot), .at_max(amax), .at_top(atop), .count_down(cdn),
		.timer_tick(ttk));
	// ****************
	// Access tasks
	// ****************
	task report_and_stop;
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task wr(input int k, input logic [7:0] d);
		@(posedge clk);
		case (k)
			0: cw <= '{1'b1, d};
			1: oaw <= '{1'b1, d};
			default: obw <= '{1'b1, d};
		endcase
		@(posedge clk);
		cw.we <= 1'b0;
		oaw.we <= 1'b0;
		obw.we <= 1'b0;
	endtask
	task setc(input logic [2:0] c, input logic [2:0] m);
		@(posedge clk);
		cs <= c;
		wm <= m;
	endtask
	task clr;
		setc(etc_pkg::CS_STOP, wm);
		fclr <= 3'h7;
		@(posedge clk);
		fclr <= 3'h0;
	endtask
	task wflag(input int b);
		int i;
		for (i = 0; i < 40 && timer_flag_register[b] !== 1'b1; i++) @(negedge clk);
		`CHK("flag", 1'b1, timer_flag_register[b])
	endtask
	task mon(input int n);
		logic [7:0] p;
		int i;
		mx = 8'h00;
		dn = 1'b0;
		p = counter_value;
		for (i = 0; i < n; i++) begin
			@(negedge clk);
			if (counter_value > mx) mx = counter_value;
			if (counter_value === p - 8'h01) dn = 1'b1;
			p = counter_value;
		end
	endtask
	task pulse;
		@(posedge clk);
		ext <= 1'b1;
		repeat (3) @(posedge clk);
		ext <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#500000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		nrst = 1'b0; clk_en = 1'b1; ext = 1'b0; cw = '0; oaw = '0; obw = '0;
		cs = 3'h0; msk = 3'h0; fclr = 3'h0; wm = 3'h0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		`CHK("reset", 27'h0, {counter_value, compare_value_a, compare_value_b, timer_flag_register})
		wr(0, 8'h55);
		cyc(10);
		`CHK("stopped", 8'h55, counter_value)
		`CHK("tick off", 1'b0, ttk)
		setc(etc_pkg::CS_DIV1, etc_pkg::WM_NORMAL);
		wr(0, 8'h40);
		cyc(1);
		`CHK("write wins", 8'h40, counter_value)
		cyc(1);
		`CHK("increment", 8'h41, counter_value)
		`CHK("tick on", 1'b1, ttk)
		@(posedge clk);
		clk_en <= 1'b0;
		cyc(3);
		`CHK("frozen", 8'h42, counter_value)
		@(posedge clk);
		clk_en <= 1'b1;
		clr;
		wr(1, 8'h30);
		wr(0, 8'h30);
		cyc(1);
		`CHK("match blocked", 1'b0, ma)
		setc(etc_pkg::CS_DIV1, etc_pkg::WM_NORMAL);
		cyc(40);
		`CHK("blocked", 1'b0, timer_flag_register[etc_pkg::FLG_CMPA])
		clr;
		wr(1, 8'h0a);
		wr(2, 8'h14);
		msk <= 3'h3;
		wr(0, 8'h08);
		cyc(1);
		`CHK("ocra", 8'h0a, compare_value_a)
		`CHK("ocrb", 8'h14, compare_value_b)
		setc(etc_pkg::CS_DIV1, etc_pkg::WM_NORMAL);
		wflag(etc_pkg::FLG_CMPA);
		`CHK("match a", 8'h0b, counter_value)
		`CHK("irq a", 1'b1, timer_irq[etc_pkg::FLG_CMPA])
		wflag(etc_pkg::FLG_CMPB);
		`CHK("match b", 8'h15, counter_value)
		`CHK("irq b", 1'b0, timer_irq[etc_pkg::FLG_CMPB])
		clr;
		cyc(2);
		`CHK("cleared", 3'h0, timer_flag_register)
		wr(0, 8'hfd);
		setc(etc_pkg::CS_DIV1, etc_pkg::WM_NORMAL);
		wflag(etc_pkg::FLG_OVF);
		`CHK("wrap", 8'h00, counter_value)
		`CHK("bottom", 1'b1, bot)
		`CHK("not max", 1'b0, amax)
		`CHK("irq ovf", 1'b1, timer_irq[etc_pkg::FLG_OVF])
		clr;
		wr(1, 8'h05);
		wr(0, 8'h00);
		setc(etc_pkg::CS_DIV1, etc_pkg::WM_CTC);
		mon(30);
		`CHK("ctc top", 9'h00a, {mx, dn})
		setc(etc_pkg::CS_DIV1, etc_pkg::WM_PC_OCA);
		mon(30);
		`CHK("pc top", 9'h00b, {mx, dn})
		clr;
		setc(etc_pkg::CS_STOP, etc_pkg::WM_NORMAL);
		wr(0, 8'h00);
		for (int k = 0; k < 2; k++) begin
			setc(k == 0 ? etc_pkg::CS_EXT_RISE : etc_pkg::CS_EXT_FALL, etc_pkg::WM_NORMAL);
			repeat (3) pulse;
			cyc(4);
			`CHK("ext count", 8'(3 * (k + 1)), counter_value)
		end
		clr;
		wr(1, 8'h07);
		wr(2, 8'h07);
		setc(etc_pkg::CS_EXT_FALL, etc_pkg::WM_NORMAL);
		pulse;
		cyc(1);
		`CHK("at match", 8'h07, counter_value)
		`CHK("eq a", 1'b1, ma)
		`CHK("eq b", 1'b1, mb)
		`CHK("not yet", 1'b0, timer_flag_register[etc_pkg::FLG_CMPA])
		pulse;
		cyc(1);
		`CHK("after match", 3'h6, timer_flag_register)
		`CHK("eq gone", 1'b0, ma)
		wr(0, 8'hff);
		cyc(1);
		`CHK("max top", 2'h3, {amax, atop})
		setc(etc_pkg::CS_EXT_FALL, etc_pkg::WM_PC_FF);
		pulse;
		cyc(1);
		`CHK("turn", 9'h1fe, {cdn, counter_value})
		report_and_stop;
	end
endmodule
`default_nettype wire
